// ---- rtl/host_ready_line_control.sv ----
// Operation
// - a drop of the node alive line sets both receive and send fault flops
// - software clears receive and send fault flops independently of each other
// - each bounce of node alive while rising sets the fault flops again
// - host alive flop drives the relay and is set and cleared by software
// - restart clears host alive, holds it half a second, then sets it
// - node alive is a readable status bit that raises no interrupt
// - fault flops are set while host alive or node alive is off
// - fault flops are readable and software clearable, never interrupt sources
// - reset never clears the fault flops
// - half second stabilizer on host alive gates strobe and bit acceptance
// - without stabilizer software waits half a second before transfers
// - after a drop each side discards its message and sends a discardable one
// - receive waits buffer and node alive; fault discards, else queues
// - send waits message and node alive; fault retransmits, else dequeues
// - shared fault claim copies flop to other flag, clears flop and own
`timescale 1ns/1ps
module host_ready_line_control #(
   parameter int unsigned HALF_SEC_CYCLES = ready_pkg::HALF_SEC_CYC
) (
   input wire logic clk, // 250 MHz clock
   input wire logic rst, // synchronous reset, high
   input wire logic [4:0] address, // avalon byte address
   input wire logic read, // avalon read
   input wire logic write, // avalon write
   input wire logic [31:0] writedata, // avalon write data
   output logic [31:0] readdata, // avalon read data
   output logic waitrequest, // avalon wait
   output logic irq, // level interrupt
   input wire logic node_alive_line, // async node alive pin
   output logic host_alive_relay, // drives host alive relay
   input wire logic host_bit_strobe, // host to node strobe, raw
   input wire logic host_accepts_next_bit, // host acceptance, raw
   output logic bit_strobe_gated, // strobe after stabilizer
   output logic accept_gated, // acceptance after stabilizer
   output logic driver_restart, // pulse: restart driver processes
   input wire logic rx_buf_free, // receive buffer available
   input wire logic rx_done, // pulse: receive complete
   output logic rx_start, // pulse: begin receive
   output logic rx_discard, // pulse: discard received message
   output logic rx_queue, // pulse: queue received message
   input wire logic tx_msg_queued, // message waiting to send
   input wire logic tx_done, // pulse: send complete
   output logic tx_start, // pulse: begin send
   output logic tx_retry, // pulse: keep message for resend
   output logic tx_flush, // pulse: send discardable message first
   output logic tx_dequeue // pulse: remove sent message
);
   import ready_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef logic [CNT_W-1:0] cnt_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic host_alive;
      logic hw_stab;
      logic rx_fault;
      logic tx_fault;
      logic sh_fault;
      logic in_flag;
      logic out_flag;
      cnt_t stab_cnt;
      logic stable;
      logic rst_busy;
      cnt_t rst_cnt;
      logic [1:0] irq_stat;
      logic [1:0] irq_mask;
      logic wait_r;
      logic [31:0] rdata;
      logic irq;
      logic strobe_o;
      logic accept_o;
      logic restart_o;
      proc_e rx_st;
      proc_e tx_st;
      logic rx_start;
      logic rx_discard;
      logic rx_queue;
      logic tx_start;
      logic tx_retry;
      logic tx_flush;
      logic tx_dequeue;
   } state_s;

   localparam cnt_t LIM = cnt_t'(HALF_SEC_CYCLES);

   state_s s_ff;
   state_s nxt_s;

   logic acc;
   logic acc_wr;
   logic link_ok;
   logic fault_set;

   assign acc = !s_ff.wait_r && (read || write);
   assign acc_wr = acc && write;
   // transfers wait for a live node, no restart and a settled host flop
   assign link_ok = s_ff.sync2 && s_ff.host_alive && !s_ff.rst_busy
      && (s_ff.stable || !s_ff.hw_stab);
   assign fault_set = !s_ff.host_alive || !s_ff.sync2;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic rx_clr;
      logic tx_clr;
      rx_clr = 1'b0;
      tx_clr = 1'b0;
      nxt_s = s_ff;

      nxt_s.sync1 = node_alive_line;
      nxt_s.sync2 = s_ff.sync1;

      // bus handshake: answer one cycle after the request appears
      nxt_s.wait_r = 1'b1;
      if (s_ff.wait_r && (read || write)) begin
         nxt_s.wait_r = 1'b0;
      end
      if (s_ff.wait_r && read) begin
         nxt_s.rdata = 32'h0;
         case (address)
            OFS_CTRL: begin
               nxt_s.rdata[CTRL_HOST_ALIVE] = s_ff.host_alive;
               nxt_s.rdata[CTRL_HW_STAB] = s_ff.hw_stab;
            end
            OFS_STATUS: begin
               nxt_s.rdata[ST_NODE_ALIVE] = s_ff.sync2;
               nxt_s.rdata[ST_RX_FAULT] = s_ff.rx_fault;
               nxt_s.rdata[ST_TX_FAULT] = s_ff.tx_fault;
               nxt_s.rdata[ST_STABLE] = s_ff.stable;
               nxt_s.rdata[ST_RST_BUSY] = s_ff.rst_busy;
            end
            OFS_IRQ_STAT: nxt_s.rdata[1:0] = s_ff.irq_stat;
            OFS_IRQ_MASK: nxt_s.rdata[1:0] = s_ff.irq_mask;
            OFS_SHARED: begin
               nxt_s.rdata[SH_FAULT] = s_ff.sh_fault;
               nxt_s.rdata[SH_IN_FLAG] = s_ff.in_flag;
               nxt_s.rdata[SH_OUT_FLAG] = s_ff.out_flag;
            end
            default: nxt_s.rdata = 32'h0;
         endcase
      end

      // register writes take effect at the completing edge
      if (acc_wr) begin
         case (address)
            OFS_CTRL: begin
               nxt_s.hw_stab = writedata[CTRL_HW_STAB];
               if (!s_ff.rst_busy) begin
                  nxt_s.host_alive = writedata[CTRL_HOST_ALIVE];
               end
               if (writedata[CTRL_RESTART]) begin
                  nxt_s.rst_busy = 1'b1;
                  nxt_s.rst_cnt = '0;
                  nxt_s.host_alive = 1'b0;
               end
            end
            OFS_STATUS: begin
               rx_clr = writedata[ST_RX_FAULT];
               tx_clr = writedata[ST_TX_FAULT];
            end
            OFS_IRQ_MASK: nxt_s.irq_mask = writedata[1:0];
            OFS_SHARED: begin
               if (writedata[SH_IN_CLAIM]) begin
                  nxt_s.out_flag = s_ff.out_flag || s_ff.sh_fault;
                  nxt_s.in_flag = 1'b0;
                  nxt_s.sh_fault = 1'b0;
               end else if (writedata[SH_OUT_CLAIM]) begin
                  nxt_s.in_flag = s_ff.in_flag || s_ff.sh_fault;
                  nxt_s.out_flag = 1'b0;
                  nxt_s.sh_fault = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (acc && read && address == OFS_IRQ_STAT) begin
         // clear only what the read returned; a later event stays pending
         nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.rdata[1:0];
      end

      if (s_ff.rst_busy) begin
         nxt_s.host_alive = 1'b0;
         nxt_s.rst_cnt = s_ff.rst_cnt + cnt_t'(1);
         if (s_ff.rst_cnt == LIM - cnt_t'(1)) begin
            nxt_s.rst_busy = 1'b0;
            nxt_s.host_alive = 1'b1;
         end
      end
      nxt_s.restart_o = s_ff.rst_busy && !nxt_s.rst_busy;
      if (nxt_s.restart_o) begin
         nxt_s.irq_stat[IRQ_RESTART_DONE] = 1'b1;
      end

      if (!s_ff.host_alive) begin
         nxt_s.stab_cnt = '0;
      end else if (s_ff.stab_cnt != LIM) begin
         nxt_s.stab_cnt = s_ff.stab_cnt + cnt_t'(1);
      end
      nxt_s.stable = s_ff.host_alive && s_ff.stab_cnt == LIM;
      if (nxt_s.stable && !s_ff.stable) begin
         nxt_s.irq_stat[IRQ_STABLE] = 1'b1;
      end
      nxt_s.strobe_o = host_bit_strobe && (s_ff.stable || !s_ff.hw_stab);
      nxt_s.accept_o = host_accepts_next_bit && (s_ff.stable || !s_ff.hw_stab);

      // receive process
      nxt_s.rx_start = 1'b0;
      nxt_s.rx_discard = 1'b0;
      nxt_s.rx_queue = 1'b0;
      case (s_ff.rx_st)
         P_WAIT: begin
            if (rx_buf_free && link_ok) begin
               nxt_s.rx_start = 1'b1;
               nxt_s.rx_st = P_BUSY;
            end
         end
         P_BUSY: begin
            if (rx_done) begin
               nxt_s.rx_st = P_WAIT;
               if (s_ff.rx_fault) begin
                  rx_clr = 1'b1;
                  nxt_s.rx_discard = 1'b1;
               end else begin
                  nxt_s.rx_queue = 1'b1;
               end
            end
         end
         default: nxt_s.rx_st = P_WAIT;
      endcase

      // send process
      nxt_s.tx_start = 1'b0;
      nxt_s.tx_retry = 1'b0;
      nxt_s.tx_flush = 1'b0;
      nxt_s.tx_dequeue = 1'b0;
      case (s_ff.tx_st)
         P_WAIT: begin
            if (tx_msg_queued && link_ok) begin
               nxt_s.tx_start = 1'b1;
               nxt_s.tx_st = P_BUSY;
            end
         end
         P_BUSY: begin
            if (tx_done) begin
               nxt_s.tx_st = P_WAIT;
               if (s_ff.tx_fault) begin
                  tx_clr = 1'b1;
                  nxt_s.tx_retry = 1'b1;
                  nxt_s.tx_flush = 1'b1;
               end else begin
                  nxt_s.tx_dequeue = 1'b1;
               end
            end
         end
         default: nxt_s.tx_st = P_WAIT;
      endcase

      if (rx_clr) begin
         nxt_s.rx_fault = 1'b0;
      end
      if (tx_clr) begin
         nxt_s.tx_fault = 1'b0;
      end
      if (fault_set) begin
         nxt_s.rx_fault = 1'b1;
         nxt_s.tx_fault = 1'b1;
         nxt_s.sh_fault = 1'b1;
      end

      nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s_ff <= '0;
         s_ff.wait_r <= RST_WAIT;
         s_ff.hw_stab <= RST_HW_STAB;
         s_ff.rx_fault <= RST_FAULT;
         s_ff.tx_fault <= RST_FAULT;
         s_ff.sh_fault <= RST_FAULT;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign readdata = s_ff.rdata;
   assign waitrequest = s_ff.wait_r;
   assign irq = s_ff.irq;
   assign host_alive_relay = s_ff.host_alive;
   assign bit_strobe_gated = s_ff.strobe_o;
   assign accept_gated = s_ff.accept_o;
   assign driver_restart = s_ff.restart_o;
   assign rx_start = s_ff.rx_start;
   assign rx_discard = s_ff.rx_discard;
   assign rx_queue = s_ff.rx_queue;
   assign tx_start = s_ff.tx_start;
   assign tx_retry = s_ff.tx_retry;
   assign tx_flush = s_ff.tx_flush;
   assign tx_dequeue = s_ff.tx_dequeue;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_fault_level;
      fault_set |=> s_ff.rx_fault && s_ff.tx_fault && s_ff.sh_fault;
   endproperty
   a_fault_level: assert property (p_fault_level) else $error("fault not set");

   property p_drop;
      $fell(s_ff.sync2) |=> s_ff.rx_fault && s_ff.tx_fault;
   endproperty
   a_drop: assert property (p_drop) else $error("drop missed");

   property p_sep_clear;
      acc_wr && address == OFS_STATUS && writedata[ST_RX_FAULT]
         && !writedata[ST_TX_FAULT] && s_ff.tx_fault |=> s_ff.tx_fault;
   endproperty
   a_sep_clear: assert property (p_sep_clear) else $error("clear not separate");

   property p_sync;
      ##2 1'b1 |-> s_ff.sync2 == $past(node_alive_line, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync depth wrong");

   property p_gate;
      s_ff.strobe_o |-> $past(host_bit_strobe) && $past(s_ff.stable || !s_ff.hw_stab);
   endproperty
   a_gate: assert property (p_gate) else $error("strobe not gated");

   property p_restart_end;
      $fell(s_ff.rst_busy) |-> s_ff.host_alive && s_ff.restart_o
         && $past(s_ff.rst_cnt) == LIM - cnt_t'(1);
   endproperty
   a_restart_end: assert property (p_restart_end) else $error("restart end wrong");

   property p_restart_low;
      s_ff.rst_busy |-> !s_ff.host_alive;
   endproperty
   a_restart_low: assert property (p_restart_low) else $error("alive during restart");

   property p_rx_start;
      s_ff.rx_start |-> $past(s_ff.sync2 && rx_buf_free) ##1 s_ff.rx_st == P_BUSY;
   endproperty
   a_rx_start: assert property (p_rx_start) else $error("rx start early");

   property p_tx_end;
      s_ff.tx_st == P_BUSY && tx_done && s_ff.tx_fault |=> s_ff.tx_retry && !s_ff.tx_dequeue;
   endproperty
   a_tx_end: assert property (p_tx_end) else $error("tx fault not kept");

   property p_claim;
      acc_wr && address == OFS_SHARED && writedata[SH_IN_CLAIM] && s_ff.sh_fault
         |=> s_ff.out_flag && !s_ff.in_flag;
   endproperty
   a_claim: assert property (p_claim) else $error("claim wrong");
endmodule

// ---- rtl/ready_pkg.sv ----
package ready_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h0c;
   localparam logic [4:0] OFS_SHARED = 5'h10;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_HOST_ALIVE = 0;
   localparam int CTRL_RESTART = 1;
   localparam int CTRL_HW_STAB = 2;
   localparam int ST_NODE_ALIVE = 0;
   localparam int ST_RX_FAULT = 1;
   localparam int ST_TX_FAULT = 2;
   localparam int ST_STABLE = 3;
   localparam int ST_RST_BUSY = 4;
   localparam int IRQ_RESTART_DONE = 0;
   localparam int IRQ_STABLE = 1;
   localparam int SH_FAULT = 0;
   localparam int SH_IN_FLAG = 1;
   localparam int SH_OUT_FLAG = 2;
   localparam int SH_IN_CLAIM = 0;
   localparam int SH_OUT_CLAIM = 1;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic RST_FAULT = 1'b1;
   localparam logic RST_WAIT = 1'b1;
   localparam logic RST_HW_STAB = 1'b1;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int HALF_SEC_US = 500000;
   localparam int HALF_SEC_CYC = HALF_SEC_US * CLK_MHZ;
   localparam int CNT_W = 27;
   // ----------------------------------------
   // driver process states
   // ----------------------------------------
   typedef enum logic [1:0] {
      P_WAIT = 2'b00,
      P_BUSY = 2'b01
   } proc_e;
endpackage

// ---- dv/node_model.sv ----
`timescale 1ns/1ps
module node_model (
   input wire logic clk, // host clock
   input wire logic want_alive, // bench: node powered and running
   input wire logic [3:0] dly, // bench: cycles a transfer takes, minus one
   input wire logic rx_start, // host begins a receive
   input wire logic tx_start, // host begins a send
   output logic node_alive_line, // alive pin seen by the host
   output logic rx_done, // receive complete
   output logic tx_done // send complete
);
   logic [2:0] bnc_ff = 3'h0;
   logic [3:0] settle_ff = 4'h0;
   logic [4:0] rx_left_ff = 5'h0;
   logic [4:0] tx_left_ff = 5'h0;
   logic settled;
   assign settled = (settle_ff == 4'hf);
   initial begin
      node_alive_line = 1'b0;
      rx_done = 1'b0;
      tx_done = 1'b0;
   end
   // ----------------------------------------
   // alive line with contact bounce
   // ----------------------------------------
   // drop loses state
   always @(posedge clk) begin
      if (!want_alive) begin
         node_alive_line <= 1'b0;
         bnc_ff <= 3'h0;
         settle_ff <= 4'h0;
      end else if (bnc_ff != 3'h7) begin
         node_alive_line <= ~node_alive_line;
         bnc_ff <= bnc_ff + 3'h1;
      end else if (!settled) begin
         settle_ff <= settle_ff + 4'h1;
      end
   end
   // ----------------------------------------
   // transfers
   // ----------------------------------------
   // completion waits settling
   always @(posedge clk) begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      if (rx_start)
         rx_left_ff <= {1'b0, dly} + 5'h1;
      else if (rx_left_ff > 5'h1 || (rx_left_ff == 5'h1 && settled)) begin
         rx_left_ff <= rx_left_ff - 5'h1;
         rx_done <= (rx_left_ff == 5'h1);
      end
      if (tx_start)
         tx_left_ff <= {1'b0, dly} + 5'h1;
      else if (tx_left_ff > 5'h1 || (tx_left_ff == 5'h1 && settled)) begin
         tx_left_ff <= tx_left_ff - 5'h1;
         tx_done <= (tx_left_ff == 5'h1);
      end
   end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import ready_pkg::*;
   localparam int HALF = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata, q;
   logic waitrequest, irq, node_alive_line, host_alive_relay;
   logic host_bit_strobe = 1'b1;
   logic host_accepts_next_bit = 1'b1;
   logic bit_strobe_gated, accept_gated, driver_restart;
   logic rx_buf_free = 1'b0;
   logic tx_msg_queued = 1'b0;
   logic rx_done, rx_start, rx_discard, rx_queue;
   logic tx_done, tx_start, tx_retry, tx_flush, tx_dequeue;
   logic want_alive = 1'b0;
   logic rnd_on = 1'b0;
   logic [3:0] dly = 4'h2;
   logic [15:0] seed = 16'hfdf8;
   logic [15:0] r;
   logic [8:0] ev;
   int cnt[9] = '{default: 0};
   int s[9];
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int lo_cnt = 0;

   always #2 clk = ~clk;

   host_ready_line_control #(.HALF_SEC_CYCLES(HALF)) dut_u (
      .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
      .node_alive_line(node_alive_line), .host_alive_relay(host_alive_relay),
      .host_bit_strobe(host_bit_strobe), .host_accepts_next_bit(host_accepts_next_bit),
      .bit_strobe_gated(bit_strobe_gated), .accept_gated(accept_gated),
      .driver_restart(driver_restart), .rx_buf_free(rx_buf_free), .rx_done(rx_done),
      .rx_start(rx_start), .rx_discard(rx_discard), .rx_queue(rx_queue),
      .tx_msg_queued(tx_msg_queued), .tx_done(tx_done), .tx_start(tx_start),
      .tx_retry(tx_retry), .tx_flush(tx_flush), .tx_dequeue(tx_dequeue));

   node_model node_u (.clk(clk), .want_alive(want_alive), .dly(dly), .rx_start(rx_start),
      .tx_start(tx_start), .node_alive_line(node_alive_line), .rx_done(rx_done),
      .tx_done(tx_done));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] xs();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed;
   endfunction

   function automatic int dl(input int i);
      return cnt[i] - s[i];
   endfunction

   task automatic conclude();
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon transfer; holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   // ----------------------------------------
   // event counters, random drive, timeout
   // ----------------------------------------
   assign ev = {tx_done, tx_flush, tx_retry, tx_dequeue, tx_start,
                rx_done, rx_discard, rx_queue, rx_start};
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (!rst) begin
         for (int i = 0; i < 9; i++)
            cnt[i] <= cnt[i] + int'(ev[i] === 1'b1);
         if (host_alive_relay === 1'b0)
            lo_cnt <= lo_cnt + 1;
      end
      if (rnd_on) begin
         r = xs();
         host_bit_strobe <= r[0];
         host_accepts_next_bit <= r[1];
         rx_buf_free <= r[2] | r[3];
         tx_msg_queued <= r[4] | r[5];
         dly <= r[9:6];
      end
      if (cyc == 6000) begin
         n_mismatch++;
         conclude();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int lo;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_STATUS, 32'h6);
      rd(OFS_CTRL, 32'h4);
      bus(1'b1, OFS_IRQ_MASK, 32'h3);
      rd(OFS_IRQ_MASK, 32'h3);
      bus(1'b1, 5'h14, 32'hffffffff);
      rd(5'h14, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h5);
      repeat (2) @(posedge clk);
      chk(32'(host_alive_relay), 32'h1);
      chk(32'(bit_strobe_gated), 32'h0);
      want_alive <= 1'b1;
      repeat (45) @(posedge clk);
      rd(OFS_STATUS, 32'hf);
      chk(32'({bit_strobe_gated, accept_gated}), 32'h3);
      chk(32'(irq), 32'h1);
      rd(OFS_IRQ_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      bus(1'b1, OFS_STATUS, 32'h2);
      rd(OFS_STATUS, 32'hd);
      bus(1'b1, OFS_STATUS, 32'h4);
      rd(OFS_STATUS, 32'h9);
      bus(1'b1, OFS_SHARED, 32'h1);
      rd(OFS_SHARED, 32'h4);
      bus(1'b1, OFS_SHARED, 32'h2);
      rd(OFS_SHARED, 32'h0);
      s = cnt;
      rnd_on <= 1'b1;
      repeat (600) @(posedge clk);
      rnd_on <= 1'b0;
      @(posedge clk);
      rx_buf_free <= 1'b0;
      tx_msg_queued <= 1'b0;
      repeat (40) @(posedge clk);
      chk(32'(dl(1)), 32'(dl(3)));
      chk(32'(dl(5)), 32'(dl(8)));
      chk(32'(dl(2) + dl(6)), 32'h0);
      chk(32'(dl(3) > 5 && dl(8) > 5), 32'h1);
      s = cnt;
      dly <= 4'hf;
      host_bit_strobe <= 1'b1;
      host_accepts_next_bit <= 1'b1;
      rx_buf_free <= 1'b1;
      tx_msg_queued <= 1'b1;
      for (int i = 0; i < 50 && !(dl(0) > 0 && dl(4) > 0); i++)
         @(posedge clk);
      rx_buf_free <= 1'b0;
      tx_msg_queued <= 1'b0;
      want_alive <= 1'b0;
      repeat (4) @(posedge clk);
      want_alive <= 1'b1;
      repeat (60) @(posedge clk);
      chk({16'(dl(2)), 16'(dl(1))}, {16'h1, 16'h0});
      chk({16'(dl(6)), 16'(dl(5))}, {16'h1, 16'h0});
      chk(32'(dl(7)), 32'h1);
      rd(OFS_STATUS, 32'h9);
      s = cnt;
      want_alive <= 1'b0;
      // let the drop reach the synchronizer before offering a buffer
      repeat (4) @(posedge clk);
      rx_buf_free <= 1'b1;
      repeat (12) @(posedge clk);
      chk(32'(dl(0)), 32'h0);
      bus(1'b1, OFS_STATUS, 32'h6);
      rd(OFS_STATUS, 32'he);
      chk(32'(irq), 32'h0);
      want_alive <= 1'b1;
      rx_buf_free <= 1'b0;
      repeat (40) @(posedge clk);
      bus(1'b1, OFS_STATUS, 32'h6);
      rd(OFS_STATUS, 32'h9);
      lo = lo_cnt;
      bus(1'b1, OFS_CTRL, 32'h6);
      rd(OFS_STATUS, 32'h17);
      for (int i = 0; i < 200 && driver_restart !== 1'b1; i++)
         @(posedge clk);
      chk(32'(lo_cnt - lo >= HALF && lo_cnt - lo <= HALF + 1), 32'h1);
      chk(32'({host_alive_relay, bit_strobe_gated}), 32'h2);
      rd(OFS_IRQ_STAT, 32'h1);
      bus(1'b1, OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'({bit_strobe_gated, accept_gated}), 32'h3);
      conclude();
   end
endmodule
